/* bench/autoneg_regs_asserts.sv */
// checker on the serial pins and codeword outputs of the register bank
`timescale 1ns/100ps
`default_nettype none
module autoneg_regs_asserts (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_B_IN,
  // watched pins
  input wire logic MDC_IN,
  input wire logic MDIO_OUT,
  input wire logic MDIO_OE_OUT,
  input wire logic NONCE_EXCHANGED_IN,
  input wire logic [4:0] PARTNER_NONCE_IN,
  input wire logic [15:0] TX_BASE_WORD_OUT,
  input wire logic [15:0] TX_ADVERT_MID_OUT
);
  logic mdc_q; // last sample of the management clock
  logic [3:0] since_rise; // edges since the last rise, saturating
  logic [4:0] oe_rises; // rises seen while we drive
  wire logic mdc_rise; // rise as the bank detects it
  assign mdc_rise = MDC_IN & ~mdc_q;
  // a spurious rise after reset only makes the checks more lenient
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      mdc_q <= 1'b0;
      since_rise <= 4'h0;
      oe_rises <= 5'h00;
    end else begin
      mdc_q <= MDC_IN;
      since_rise <= mdc_rise ? 4'h0 : since_rise + {3'h0, since_rise != 4'hf};
      oe_rises <= !MDIO_OE_OUT ? 5'h00 : oe_rises + {4'h0, mdc_rise};
    end
  end
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  sequence s_drive_start;
    $rose(MDIO_OE_OUT);
  endsequence
  sequence s_drive_end;
    $fell(MDIO_OE_OUT);
  endsequence
  a_ack_always_zero: assert property (!TX_BASE_WORD_OUT[14])
    else $error("ack bit of codeword set");
  a_nonce_follows: assert property (NONCE_EXCHANGED_IN |=>
    TX_BASE_WORD_OUT[9:5] == $past(PARTNER_NONCE_IN))
    else $error("echo field not partner nonce");
  a_nonce_unused: assert property (!NONCE_EXCHANGED_IN &&
    !$past(NONCE_EXCHANGED_IN) && since_rise > 4'h5
    |=> $stable(TX_BASE_WORD_OUT[9:5]))
    else $error("echo field moved without a write");
  a_fields_quiet: assert property (since_rise > 4'h5 |=>
    $stable(TX_BASE_WORD_OUT[15:10]) && $stable(TX_BASE_WORD_OUT[4:0])
    && $stable(TX_ADVERT_MID_OUT))
    else $error("codeword field moved without a write");
  a_oe_on_rise: assert property (s_drive_start |-> $past(mdc_rise))
    else $error("drive started off a clock rise");
  a_oe_first_low: assert property (s_drive_start |-> !MDIO_OUT)
    else $error("first driven bit not zero");
  a_out_on_rise: assert property ($changed(MDIO_OUT) |-> $past(mdc_rise))
    else $error("read data changed between rises");
  a_drive_length: assert property (s_drive_end |-> oe_rises == 5'h11)
    else $error("drive window not seventeen rises");
endmodule : autoneg_regs_asserts
bind autoneg_status_advert_regs autoneg_regs_asserts chk (
  .REF_CLK_IN(REF_CLK_IN), .RST_B_IN(RST_B_IN), .MDC_IN(MDC_IN),
  .MDIO_OUT(MDIO_OUT), .MDIO_OE_OUT(MDIO_OE_OUT),
  .NONCE_EXCHANGED_IN(NONCE_EXCHANGED_IN),
  .PARTNER_NONCE_IN(PARTNER_NONCE_IN),
  .TX_BASE_WORD_OUT(TX_BASE_WORD_OUT),
  .TX_ADVERT_MID_OUT(TX_ADVERT_MID_OUT));
`default_nettype wire

/* bench/mdio_station.sv */
// management station model sending serial frames
`timescale 1ns/100ps
`default_nettype none
module mdio_station (
  // clock
  input wire logic clk_in,
  // device side of the data line
  input wire logic mdio_out_in,
  input wire logic mdio_oe_in,
  // lines towards the device
  output logic mdc_out,
  output logic mdio_out
);
  logic drive; // station owns the data line
  logic bit_val; // level the station puts out
  // a released line floats up to the pull-up level
  assign mdio_out = mdio_oe_in ? mdio_out_in : (drive ? bit_val : 1'b1);
  initial begin
    mdc_out = 1'b0;
    drive = 1'b0;
    bit_val = 1'b1;
  end
  // one bit: two clocks low with data set, two clocks high
  task automatic send(input logic b, input logic own, output logic s);
    drive <= own;
    bit_val <= b;
    mdc_out <= 1'b0;
    repeat (2) @(posedge clk_in);
    s = mdio_out; // read data is steady just before the rise
    mdc_out <= 1'b1;
    repeat (2) @(posedge clk_in);
  endtask : send
  // whole frame; reads release the line from the turnaround on
  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
    input logic [4:0] da, input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic s;
    hdr = {2'b00, op, pa, da};
    for (int i = 0; i < 32; i++) send(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) send(hdr[i], 1'b1, s);
    send(1'b1, !op[1], s);
    send(1'b0, !op[1], s);
    for (int i = 15; i >= 0; i--) begin
      send(wd[i], !op[1], s);
      rd[i] = s;
    end
    drive <= 1'b0;
    repeat (6) @(posedge clk_in); // lets a write land
  endtask : frame
endmodule : mdio_station
`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the negotiation register bank
`timescale 1ns/100ps
`default_nettype none
module tb import autoneg_regs_pkg::*; ;
  logic ref_clk = 1'b0; // core clock
  logic rst_b = 1'b0; // active-low reset
  logic [6:0] cond = 7'h02; // condition inputs, ext next page up
  logic nonce_ok = 1'b0; // nonce exchange finished
  logic [4:0] lp_nonce = 5'h0a; // partner nonce
  logic mdc, mdio, mdio_d, mdio_oe;
  logic [15:0] tx_word, tx_mid;
  logic [4:0] port_addr = 5'h03; // our port address
  int pos [7] = '{9, 7, 6, 5, 4, 2, 0}; // status bit of each condition
  int mismatches = 0;
  int n_compared = 0;
  always #2 ref_clk = ~ref_clk;
  mdio_station stn (.clk_in(ref_clk), .mdio_out_in(mdio_d),
    .mdio_oe_in(mdio_oe), .mdc_out(mdc), .mdio_out(mdio));
  autoneg_status_advert_regs dut (.REF_CLK_IN(ref_clk), .RST_B_IN(rst_b),
    .MDC_IN(mdc), .MDIO_IN(mdio), .MDIO_OUT(mdio_d), .MDIO_OE_OUT(mdio_oe),
    .PORT_ADDR_IN(port_addr), .PAR_DET_FAULT_IN(cond[0]),
    .EXT_NP_IN_USE_IN(cond[1]), .PAGE_RECEIVED_IN(cond[2]),
    .NEG_DONE_IN(cond[3]), .REMOTE_FAULT_IN(cond[4]),
    .LINK_UP_IN(cond[5]), .PARTNER_CAPABLE_IN(cond[6]),
    .NONCE_EXCHANGED_IN(nonce_ok), .PARTNER_NONCE_IN(lp_nonce),
    .TX_BASE_WORD_OUT(tx_word), .TX_ADVERT_MID_OUT(tx_mid));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  // pointer frame, then plain read
  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    stn.frame(OP_ADDR, port_addr, MMD_DEVAD, a, v);
    stn.frame(OP_READ, port_addr, MMD_DEVAD, 16'h0000, v);
  endtask : rd
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] v;
    stn.frame(OP_ADDR, port_addr, MMD_DEVAD, a, v);
    stn.frame(OP_WRITE, port_addr, MMD_DEVAD, d, v);
  endtask : wr
  task automatic t_reset;
    logic [15:0] v;
    check(tx_word, RST_ADV_LOW);
    check(tx_mid, RST_ADV_MID);
    rd(OFS_STATUS, v);
    check(v, RST_STATUS);
    rd(OFS_PRESENCE, v);
    check(v, PRESENCE_VALUE);
    rd(OFS_ADV_LOW, v);
    check(v, RST_ADV_LOW);
  endtask : t_reset
  // each live condition alone shows in its own bit
  task automatic t_live;
    logic [15:0] v;
    int idx [4] = '{1, 2, 3, 6};
    foreach (idx[i]) begin
      cond <= 7'h01 << idx[i];
      rd(OFS_STATUS, v);
      check(v, 16'h0008 | (16'h0001 << pos[idx[i]]));
    end
    cond <= 7'h00;
    rd(OFS_STATUS, v);
    check(v, 16'h0008);
  endtask : t_live
  // one-clock events must survive until the next read
  task automatic t_latch;
    logic [15:0] v;
    cond <= 7'h11;
    tick(1);
    cond <= 7'h00;
    rd(OFS_STATUS, v);
    check(v, 16'h0218);
    rd(OFS_STATUS, v);
    check(v, 16'h0008);
    cond <= 7'h20;
    rd(OFS_STATUS, v); // clears a drop seen while the link was down
    rd(OFS_STATUS, v);
    check(v, 16'h000c);
    cond <= 7'h00;
    tick(1);
    cond <= 7'h20;
    rd(OFS_STATUS, v);
    check(v, 16'h0008);
    rd(OFS_STATUS, v);
    check(v, 16'h000c);
  endtask : t_latch
  task automatic t_advert;
    logic [15:0] v;
    wr(OFS_ADV_LOW, 16'hffff);
    check(tx_word, 16'hbfff);
    rd(OFS_ADV_LOW, v);
    check(v, 16'hbfff);
    nonce_ok <= 1'b1;
    tick(2);
    check(tx_word, 16'hbd5f);
    rd(OFS_ADV_LOW, v);
    check(v, 16'hbfff);
    nonce_ok <= 1'b0;
    wr(OFS_ADV_LOW, 16'h0000);
    check(tx_word, 16'h0000);
  endtask : t_advert
  // read-only, unmapped, foreign frames and pointer stepping
  task automatic t_refuse;
    logic [15:0] v;
    cond <= 7'h00;
    wr(OFS_STATUS, 16'hffff);
    rd(OFS_STATUS, v);
    check(v, 16'h0008);
    wr(OFS_PRESENCE, 16'h0000);
    rd(OFS_PRESENCE, v);
    check(v, PRESENCE_VALUE);
    rd(16'h0020, v);
    check(v, 16'h0000);
    wr(OFS_ADV_MID, 16'ha5c3);
    check(tx_mid, 16'ha5c3);
    stn.frame(OP_WRITE, port_addr, 5'h03, 16'h1234, v);
    stn.frame(OP_WRITE, 5'h04, MMD_DEVAD, 16'h5678, v);
    stn.frame(OP_READ, port_addr, 5'h03, 16'h0000, v);
    check(v, 16'hffff);
    stn.frame(OP_ADDR, port_addr, MMD_DEVAD, OFS_ADV_LOW, v);
    stn.frame(OP_READ_INC, port_addr, MMD_DEVAD, 16'h0000, v);
    check(v, 16'h0000);
    stn.frame(OP_READ, port_addr, MMD_DEVAD, 16'h0000, v);
    check(v, 16'ha5c3);
  endtask : t_refuse
  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    tick(1);
    t_reset;
    t_live;
    t_latch;
    t_advert;
    t_refuse;
    end_of_test;
  end
  // hang guard
  initial begin
    repeat (90000) @(posedge ref_clk);
    mismatches++;
    end_of_test;
  end
endmodule : tb
`default_nettype wire

/* rtl/autoneg_regs_pkg.sv */
// constants for the auto-negotiation status and advertisement register bank
package autoneg_regs_pkg;
  // management frame addressing
  localparam logic [4:0] MMD_DEVAD = 5'h07;
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [4:0] HDR_LAST = 5'h0b;
  localparam logic [4:0] DATA_LAST = 5'h0f;
  // frame opcodes
  localparam logic [1:0] OP_ADDR = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ_INC = 2'h2;
  localparam logic [1:0] OP_READ = 2'h3;
  // register offsets
  localparam logic [15:0] OFS_STATUS = 16'h0001;
  localparam logic [15:0] OFS_PRESENCE = 16'h0005;
  localparam logic [15:0] OFS_ADV_LOW = 16'h0010;
  localparam logic [15:0] OFS_ADV_MID = 16'h0011;
  // reset and constant values
  localparam logic [15:0] RST_STATUS = 16'h0088;
  localparam logic [15:0] PRESENCE_VALUE = 16'h0080;
  localparam logic [15:0] RST_ADV_LOW = 16'h1001;
  localparam logic [15:0] RST_ADV_MID = 16'h0080;
  localparam logic [2:0] RST_CAPS = 3'h4;
  localparam logic [4:0] RST_ECHO = 5'h00;
  localparam logic [4:0] RST_SEL = 5'h01;
  // status bit positions
  localparam int ST_PD_FAULT = 9;
  localparam int ST_EXT_NP = 7;
  localparam int ST_PAGE_RX = 6;
  localparam int ST_DONE = 5;
  localparam int ST_RFAULT = 4;
  localparam int ST_CAPABLE = 3;
  localparam int ST_LINK = 2;
  localparam int ST_LP_CAPABLE = 0;
  // advertisement field positions
  localparam int ADV_NP = 15;
  localparam int ADV_ACK = 14;
  localparam int ADV_RF = 13;
  localparam int ADV_CAPS_LSB = 10;
  localparam int ADV_ECHO_LSB = 5;
  localparam int ADV_SEL_LSB = 0;
endpackage : autoneg_regs_pkg

/* rtl/autoneg_status_advert_regs.sv */
// auto-negotiation status, presence and base-page advertisement registers
`timescale 1ns/100ps
`default_nettype none

// Contract
// - parallel detect fault latches high in bit 9
// - bit 7 shows extended next page use
// - bit 6 shows a page was received
// - bit 5 shows negotiation has finished
// - remote fault latches high in bit 4
// - bit 3 always reads one
// - bit 0 shows partner can negotiate
// - presence register reads bit 7 set only
// - advert bit 15 drives next page, resets 0
// - advert bit 14 always reads zero
// - advert bit 13 drives remote fault bit
// - advert bits 12:10 drive caps, reset 100
// - echoed nonce becomes partner nonce after exchange
// - echoed nonce reads last written value
// - advert bits 4:0 drive selector, reset 00001
module autoneg_status_advert_regs import autoneg_regs_pkg::*; (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_B_IN,
  // management serial pins
  input wire logic MDC_IN,
  input wire logic MDIO_IN,
  output logic MDIO_OUT,
  output logic MDIO_OE_OUT,
  input wire logic [4:0] PORT_ADDR_IN,
  // conditions from the negotiation logic
  input wire logic PAR_DET_FAULT_IN,
  input wire logic EXT_NP_IN_USE_IN,
  input wire logic PAGE_RECEIVED_IN,
  input wire logic NEG_DONE_IN,
  input wire logic REMOTE_FAULT_IN,
  input wire logic LINK_UP_IN,
  input wire logic PARTNER_CAPABLE_IN,
  // nonce exchange from the negotiation logic
  input wire logic NONCE_EXCHANGED_IN,
  input wire logic [4:0] PARTNER_NONCE_IN,
  // codeword bits towards the transmitter
  output logic [15:0] TX_BASE_WORD_OUT,
  output logic [15:0] TX_ADVERT_MID_OUT
);
  // register address pointer, loaded by address frames
  logic [15:0] mmd_addr;
  // low advertisement fields
  logic adv_nextpage_bit;
  logic adv_fault_bit;
  logic [2:0] adv_pause_caps;
  logic [4:0] adv_echoed_random_tag; // software copy, sent only while NONCE_EXCHANGED_IN is low
  logic [4:0] adv_protocol_selector;
  // middle advertisement word, plain storage
  logic [15:0] adv_mid;
  // latches for the sticky status bits
  logic lat_pd_fault; // parallel detect fault seen
  logic lat_rfault; // remote fault seen
  logic lat_link_down; // link dropped since last read

  // commands from the frame engine
  logic rd_pulse; // read snapshot strobe, combinational
  logic addr_pulse; // address frame completed
  logic wr_pulse; // write frame completed
  logic rd_done; // read frame completed
  logic rd_inc; // read frame asked for post-increment
  logic [15:0] frame_data; // data field of the last frame

  // offset compare, shared by the read mux, writes and clears
  function automatic logic reg_hit(input logic [15:0] addr,
                                   input logic [15:0] ofs);
    reg_hit = (addr == ofs);
  endfunction : reg_hit

  // register selection for the current pointer
  wire hit_status = reg_hit(mmd_addr, OFS_STATUS);
  wire hit_presence = reg_hit(mmd_addr, OFS_PRESENCE);
  wire hit_adv_low = reg_hit(mmd_addr, OFS_ADV_LOW);
  wire hit_adv_mid = reg_hit(mmd_addr, OFS_ADV_MID);

  // clearing happens on the same edge as the snapshot, so a read always
  // sees the latched value it is about to clear
  wire status_read = rd_pulse & hit_status;
  wire wr_adv_low = wr_pulse & hit_adv_low;
  wire wr_adv_mid = wr_pulse & hit_adv_mid;

  // fault flags show the latch or the live condition
  wire pd_fault_view = lat_pd_fault | PAR_DET_FAULT_IN;
  wire rfault_view = lat_rfault | REMOTE_FAULT_IN;
  // link reads low once it has dropped, until the status read
  wire link_view = LINK_UP_IN & ~lat_link_down;

  // assembled status word, reserved bits read as zero
  logic [15:0] status_word;
  always_comb begin
    status_word = 16'h0000;
    status_word[ST_PD_FAULT] = pd_fault_view;
    status_word[ST_EXT_NP] = EXT_NP_IN_USE_IN;
    status_word[ST_PAGE_RX] = PAGE_RECEIVED_IN;
    status_word[ST_DONE] = NEG_DONE_IN;
    status_word[ST_RFAULT] = rfault_view;
    status_word[ST_CAPABLE] = RST_STATUS[ST_CAPABLE];
    status_word[ST_LINK] = link_view;
    status_word[ST_LP_CAPABLE] = PARTNER_CAPABLE_IN;
  end

  // low advertisement word as software reads it back
  logic [15:0] adv_low_word;
  always_comb begin
    adv_low_word = 16'h0000;
    adv_low_word[ADV_NP] = adv_nextpage_bit;
    adv_low_word[ADV_ACK] = 1'b0;
    adv_low_word[ADV_RF] = adv_fault_bit;
    adv_low_word[ADV_CAPS_LSB +: 3] = adv_pause_caps;
    adv_low_word[ADV_ECHO_LSB +: 5] = adv_echoed_random_tag;
    adv_low_word[ADV_SEL_LSB +: 5] = adv_protocol_selector;
  end

  // the echoed nonce on the line switches to the partner's value once
  // both ends have swapped unique nonces; software never sees this
  wire [4:0] echo_on_line = NONCE_EXCHANGED_IN ? PARTNER_NONCE_IN :
                            adv_echoed_random_tag;

  // word handed to the transmitter; the acknowledge bit stays zero here
  // because the negotiation logic inserts it itself
  logic [15:0] tx_word;
  always_comb begin
    tx_word = adv_low_word;
    tx_word[ADV_ECHO_LSB +: 5] = echo_on_line;
  end

  // read data for the pointer; unmapped offsets answer zero
  wire [15:0] rd_data = hit_status ? status_word :
                        hit_presence ? PRESENCE_VALUE :
                        hit_adv_low ? adv_low_word :
                        hit_adv_mid ? adv_mid : 16'h0000;

  // serial frame engine
  mdio_c45_engine u_engine (
    .clk_in(REF_CLK_IN),
    .rst_b_in(RST_B_IN),
    .mdc_in(MDC_IN),
    .mdio_in(MDIO_IN),
    .mdio_out(MDIO_OUT),
    .mdio_oe_out(MDIO_OE_OUT),
    .port_addr_in(PORT_ADDR_IN),
    .rd_data_in(rd_data),
    .rd_pulse_out(rd_pulse),
    .addr_pulse_out(addr_pulse),
    .wr_pulse_out(wr_pulse),
    .rd_done_out(rd_done),
    .rd_inc_out(rd_inc),
    .data_out(frame_data)
  );

  // pointer: loaded by address frames, stepped after incrementing reads
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      mmd_addr <= 16'h0000;
    end else if (addr_pulse) begin
      mmd_addr <= frame_data;
    end else if (rd_done & rd_inc) begin
      mmd_addr <= mmd_addr + 16'h0001;
    end
  end

  // sticky bits: an event in the clearing cycle wins over the clear
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      lat_pd_fault <= 1'b0;
      lat_rfault <= 1'b0;
      lat_link_down <= 1'b0;
    end else begin
      lat_pd_fault <= PAR_DET_FAULT_IN |
                      (lat_pd_fault & ~status_read);
      lat_rfault <= REMOTE_FAULT_IN |
                    (lat_rfault & ~status_read);
      lat_link_down <= ~LINK_UP_IN |
                       (lat_link_down & ~status_read);
    end
  end

  // low advertisement fields; the acknowledge bit has no storage
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      adv_nextpage_bit <= RST_ADV_LOW[ADV_NP];
      adv_fault_bit <= RST_ADV_LOW[ADV_RF];
      adv_pause_caps <= RST_CAPS;
      adv_echoed_random_tag <= RST_ECHO;
      adv_protocol_selector <= RST_SEL;
    end else if (wr_adv_low) begin
      adv_nextpage_bit <= frame_data[ADV_NP];
      adv_fault_bit <= frame_data[ADV_RF];
      adv_pause_caps <= frame_data[ADV_CAPS_LSB +: 3];
      adv_echoed_random_tag <= frame_data[ADV_ECHO_LSB +: 5];
      adv_protocol_selector <= frame_data[ADV_SEL_LSB +: 5];
    end
  end

  // middle advertisement word, written whole
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      adv_mid <= RST_ADV_MID;
    end else if (wr_adv_mid) begin
      adv_mid <= frame_data;
    end
  end

  // transmitter-facing words are registered to keep the path short
  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      TX_BASE_WORD_OUT <= RST_ADV_LOW;
      TX_ADVERT_MID_OUT <= RST_ADV_MID;
    end else begin
      TX_BASE_WORD_OUT <= tx_word;
      TX_ADVERT_MID_OUT <= adv_mid;
    end
  end
endmodule : autoneg_status_advert_regs
`default_nettype wire

/* rtl/mdio_c45_engine.sv */
// serial management frame engine: preamble, header, turnaround and data
`timescale 1ns/100ps
`default_nettype none
module mdio_c45_engine import autoneg_regs_pkg::*; (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // serial pins, sampled on the core clock
  input wire logic mdc_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_out,
  // local port address and read data
  input wire logic [4:0] port_addr_in,
  input wire logic [15:0] rd_data_in,
  // decoded commands
  output logic rd_pulse_out,
  output logic addr_pulse_out,
  output logic wr_pulse_out,
  output logic rd_done_out,
  output logic rd_inc_out,
  output logic [15:0] data_out
);
  typedef enum logic [2:0] {S_PRE, S_ST, S_HDR, S_TA, S_DATA} phase_e;
  phase_e phase; // frame position
  logic mdc_prev; // last sampled serial clock
  logic [5:0] ones; // preamble ones seen, saturating
  logic [4:0] cnt; // bit counter inside a field
  logic [11:0] hdr; // opcode, port and device fields
  logic [15:0] shreg; // data shifter both ways
  logic match; // frame is addressed to us
  logic [1:0] op; // opcode of the current frame

  wire mdc_rise = mdc_in & ~mdc_prev;
  wire [11:0] hdr_next = {hdr[10:0], mdio_in};
  wire hdr_match = (hdr_next[9:5] == port_addr_in) &&
                   (hdr_next[4:0] == MMD_DEVAD);
  wire reading = match & op[1];

  // snapshot strobe is combinational so that latch clears share its edge
  assign rd_pulse_out = mdc_rise && (phase == S_TA) && (cnt == 5'h00) &&
                        reading;

  // frame sequencer, advanced on each rising serial clock
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      phase <= S_PRE;
      mdc_prev <= 1'b0;
      ones <= 6'h00;
      cnt <= 5'h00;
      hdr <= 12'h000;
      shreg <= 16'h0000;
      match <= 1'b0;
      op <= OP_ADDR;
      mdio_out <= 1'b0;
      mdio_oe_out <= 1'b0;
      addr_pulse_out <= 1'b0;
      wr_pulse_out <= 1'b0;
      rd_done_out <= 1'b0;
      rd_inc_out <= 1'b0;
      data_out <= 16'h0000;
    end else begin
      mdc_prev <= mdc_in;
      addr_pulse_out <= 1'b0;
      wr_pulse_out <= 1'b0;
      rd_done_out <= 1'b0;
      rd_inc_out <= 1'b0;
      if (mdc_rise) begin
        unique case (phase)
          // a zero after a full preamble starts a frame
          S_PRE: begin
            if (mdio_in) begin
              if (ones != PREAMBLE_ONES) ones <= ones + 6'h01;
            end else begin
              if (ones == PREAMBLE_ONES) phase <= S_ST;
              ones <= 6'h00;
            end
          end
          // second start bit must be zero for this frame format
          S_ST: begin
            phase <= mdio_in ? S_PRE : S_HDR;
            cnt <= 5'h00;
          end
          S_HDR: begin
            hdr <= hdr_next;
            cnt <= cnt + 5'h01;
            if (cnt == HDR_LAST) begin
              phase <= S_TA;
              cnt <= 5'h00;
              match <= hdr_match;
              op <= hdr_next[11:10];
            end
          end
          // on a read we drive zero in the second turnaround bit
          S_TA: begin
            cnt <= cnt + 5'h01;
            if (cnt == 5'h00) begin
              if (reading) begin
                shreg <= rd_data_in;
                mdio_oe_out <= 1'b1;
                mdio_out <= 1'b0;
              end
            end else begin
              phase <= S_DATA;
              cnt <= 5'h00;
              if (reading) begin
                mdio_out <= shreg[15];
                shreg <= {shreg[14:0], 1'b0};
              end
            end
          end
          S_DATA: begin
            mdio_out <= shreg[15];
            shreg <= {shreg[14:0], mdio_in};
            cnt <= cnt + 5'h01;
            if (cnt == DATA_LAST) begin
              phase <= S_PRE;
              ones <= 6'h00;
              mdio_oe_out <= 1'b0;
              data_out <= {shreg[14:0], mdio_in};
              addr_pulse_out <= match && (op == OP_ADDR);
              wr_pulse_out <= match && (op == OP_WRITE);
              rd_done_out <= reading;
              rd_inc_out <= match && (op == OP_READ_INC);
            end
          end
        endcase
      end
    end
  end
endmodule : mdio_c45_engine
`default_nettype wire
